// File: core/qbp_map.vh
`ifndef QBP_MAP_VH
`define QBP_MAP_VH
// port latch reset value and the value forced into port 0 by bus use
`define QBP_LATCH_RST 8'hFF
`define QBP_P0_EXT_FILL 8'hFF
// bit positions of alternate functions on port 1
`define QBP_P1_T2_CLK 0
`define QBP_P1_T2_RELOAD 1
// bit positions of alternate functions on port 3
`define QBP_P3_SER_IN 0
`define QBP_P3_SER_OUT 1
`define QBP_P3_EXT_INTERRUPT_ZERO_PIN 2
`define QBP_P3_EXT_INTERRUPT_ONE_PIN 3
`define QBP_P3_T0_CLK 4
`define QBP_P3_T1_CLK 5
`define QBP_P3_WR_STB 6
`define QBP_P3_RD_STB 7
// port numbers as used on the strobe vectors
`define QBP_PORT0 0
`define QBP_PORT1 1
`define QBP_PORT2 2
`define QBP_PORT3 3
`endif

// File: core/qbp_port_top.v
`timescale 1ns/1ps
`include "qbp_map.vh"
module qbp_port_top (
  input wire sys_clk, // 250 MHz core clock
  input wire rst_n, // synchronous reset, active low
  // core timing slots, one-cycle pulses
  input wire s6p2, // state 6 phase 2 slot
  input wire ph1, // phase 1 slot of any state
  input wire state1_phase1_slot, // state 1 phase 1 slot
  input wire state1_phase2_slot, // state 1 phase 2 slot
  // internal bus side
  input wire [3:0] wr_port, // byte write strobe per port
  input wire [3:0] bit_wr_port, // single-bit write strobe per port
  input wire [2:0] bit_idx, // bit addressed by a bit write
  input wire bit_val, // value for the addressed bit
  input wire [7:0] bus_wdata, // byte from internal bus
  input wire [3:0] rd_port, // read strobe per port
  input wire rd_rmw, // read belongs to a read-modify-write
  output reg [7:0] bus_rdata_r, // byte returned to the bus
  output reg bus_rvalid_r, // one-cycle pulse with bus_rdata_r
  // external memory control
  input wire ext_mem, // external access in progress
  input wire ext_addr16, // access uses a 16-bit address
  input wire ext_drive, // port 0 emits address or write data
  input wire [7:0] mux_addr_data_low, // low address or write data
  input wire [7:0] addr_high_byte, // high address byte
  output reg [7:0] ext_rdata_r, // byte sampled from port 0 pins
  // port 0 pins
  input wire [7:0] p0_pin_i, // pin level
  output reg [7:0] p0_pin_o, // driven level
  output reg [7:0] p0_pin_oe, // drive enable, high drives
  output reg [7:0] p0_pullup_r, // port 0 pullup on
  // port 1 pins
  input wire [7:0] p1_pin_i, // pin level
  output wire [7:0] p1_pin_o, // driven level, always low
  output wire [7:0] p1_pin_oe, // low-side driver on
  output wire [7:0] p1_pu_strong, // strong_pullup_pulse
  output wire [7:0] p1_pu_weak, // weak_keeper_pullup
  output wire [7:0] p1_pu_vweak, // very_weak_pullup
  // port 2 pins
  input wire [7:0] p2_pin_i, // pin level
  output wire [7:0] p2_pin_o, // driven level, always low
  output wire [7:0] p2_pin_oe, // low-side driver on
  output wire [7:0] p2_pu_strong, // strong_pullup_pulse
  output wire [7:0] p2_pu_weak, // weak_keeper_pullup
  output wire [7:0] p2_pu_vweak, // very_weak_pullup
  // port 3 pins
  input wire [7:0] p3_pin_i, // pin level
  output wire [7:0] p3_pin_o, // driven level, always low
  output wire [7:0] p3_pin_oe, // low-side driver on
  output wire [7:0] p3_pu_strong, // strong_pullup_pulse
  output wire [7:0] p3_pu_weak, // weak_keeper_pullup
  output wire [7:0] p3_pu_vweak, // very_weak_pullup
  // alternate output functions
  input wire timer_two_clock_out, // timer 2 clock out
  input wire serial_out_alt, // serial port output
  input wire wr_strobe_alt_n, // external write strobe, active low
  input wire rd_strobe_alt_n, // external read strobe, active low
  // alternate input functions
  output wire timer_two_clock_pin, // timer 2 clock in
  output wire timer_two_reload_capture_pin, // timer 2 reload/capture
  output wire serial_in_pin, // serial port input
  output wire ext_interrupt_zero_pin, // external interrupt 0
  output wire ext_interrupt_one_pin, // external interrupt 1
  output wire timer_zero_clock_pin, // timer 0 clock in
  output wire timer_one_clock_pin // timer 1 clock in
);
  reg [7:0] port_zero_latch;
  reg [7:0] port_one_latch;
  reg [7:0] port_two_latch;
  reg [7:0] port_three_latch;
  reg [7:0] port_zero_nxt;
  reg [7:0] port_one_nxt;
  reg [7:0] port_two_nxt;
  reg [7:0] port_three_nxt;
  reg [7:0] rdata_nxt;
  wire [7:0] p0_sync;
  wire [7:0] p1_sync;
  wire [7:0] p2_sync;
  wire [7:0] p3_sync;
  wire [7:0] p1_alt_out;
  wire [7:0] p3_alt_out;
  wire [7:0] p1_drive;
  wire [7:0] p2_drive;
  wire [7:0] p3_drive;
  wire [7:0] p2_force;
  wire p2_addr_mode;
  wire [3:0] rd_latch;
  wire [3:0] rd_pin;

  // every pin passes two flops before anything reads it
  qbp_sync2 u_sync0 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(p0_pin_i),
    .sync_out(p0_sync)
  );
  qbp_sync2 u_sync1 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(p1_pin_i),
    .sync_out(p1_sync)
  );
  qbp_sync2 u_sync2 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(p2_pin_i),
    .sync_out(p2_sync)
  );
  qbp_sync2 u_sync3 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(p3_pin_i),
    .sync_out(p3_sync)
  );

  // a byte write and a bit write share the latch path
  function [7:0] qbp_upd;
    input [7:0] cur;
    input wr;
    input bwr;
    input [7:0] wdata;
    input [2:0] idx;
    input val;
    reg [7:0] tmp;
    begin
      tmp = cur;
      if (s6p2 && wr)
        tmp = wdata;
      else if (s6p2 && bwr)
        tmp[idx] = val;
      qbp_upd = tmp;
    end
  endfunction

  always @* begin
    port_zero_nxt = qbp_upd(port_zero_latch, wr_port[`QBP_PORT0],
      bit_wr_port[`QBP_PORT0], bus_wdata, bit_idx, bit_val);
    // bus use wipes port 0 so the pins float when it ends
    if (ext_mem)
      port_zero_nxt = `QBP_P0_EXT_FILL;
    port_one_nxt = qbp_upd(port_one_latch, wr_port[`QBP_PORT1],
      bit_wr_port[`QBP_PORT1], bus_wdata, bit_idx, bit_val);
    // port 2 keeps its content through a bus access
    port_two_nxt = qbp_upd(port_two_latch, wr_port[`QBP_PORT2],
      bit_wr_port[`QBP_PORT2], bus_wdata, bit_idx, bit_val);
    port_three_nxt = qbp_upd(port_three_latch, wr_port[`QBP_PORT3],
      bit_wr_port[`QBP_PORT3], bus_wdata, bit_idx, bit_val);
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      port_zero_latch <= `QBP_LATCH_RST;
      port_one_latch <= `QBP_LATCH_RST;
      port_two_latch <= `QBP_LATCH_RST;
      port_three_latch <= `QBP_LATCH_RST;
    end else begin
      port_zero_latch <= port_zero_nxt;
      port_one_latch <= port_one_nxt;
      port_two_latch <= port_two_nxt;
      port_three_latch <= port_three_nxt;
    end
  end

  // read path: the rmw class sees the latch, others see the pin
  assign rd_latch = rd_port & {4{rd_rmw}};
  assign rd_pin = rd_port & {4{~rd_rmw}};

  always @* begin
    rdata_nxt = 8'h00;
    if (rd_latch[`QBP_PORT0])
      rdata_nxt = port_zero_latch;
    else if (rd_latch[`QBP_PORT1])
      rdata_nxt = port_one_latch;
    else if (rd_latch[`QBP_PORT2])
      rdata_nxt = port_two_latch;
    else if (rd_latch[`QBP_PORT3])
      rdata_nxt = port_three_latch;
    else if (rd_pin[`QBP_PORT0])
      rdata_nxt = p0_sync;
    else if (rd_pin[`QBP_PORT1])
      rdata_nxt = p1_sync;
    else if (rd_pin[`QBP_PORT2])
      rdata_nxt = p2_sync;
    else if (rd_pin[`QBP_PORT3])
      rdata_nxt = p3_sync;
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      bus_rdata_r <= 8'h00;
      bus_rvalid_r <= 1'b0;
      ext_rdata_r <= 8'h00;
    end else begin
      bus_rdata_r <= rdata_nxt;
      bus_rvalid_r <= |rd_port;
      // port 0 input buffers carry read data in bus mode
      if (ext_mem && !ext_drive)
        ext_rdata_r <= p0_sync;
    end
  end

  // port 0: true bidirectional, no pullup outside bus mode
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      p0_pin_o <= 8'h00;
      p0_pin_oe <= 8'h00;
      p0_pullup_r <= 8'h00;
    end else if (ph1) begin
      if (ext_mem && ext_drive) begin
        p0_pin_o <= mux_addr_data_low;
        p0_pin_oe <= 8'hFF;
        p0_pullup_r <= mux_addr_data_low;
      end else if (ext_mem) begin
        p0_pin_o <= 8'h00;
        p0_pin_oe <= 8'h00;
        p0_pullup_r <= 8'h00;
      end else begin
        // a one leaves both drivers off: open drain or input
        p0_pin_o <= 8'h00;
        p0_pin_oe <= ~port_zero_latch;
        p0_pullup_r <= 8'h00;
      end
    end
  end

  // alternate outputs idle high, so unused bits follow the latch
  assign p1_alt_out = {6'h3F, 1'b1, timer_two_clock_out};
  assign p3_alt_out = {rd_strobe_alt_n, wr_strobe_alt_n, 4'hF,
    serial_out_alt, 1'b1};

  // a zero latch pins the bit low whatever the alternate does
  assign p1_drive = port_one_latch & p1_alt_out;
  assign p3_drive = port_three_latch & p3_alt_out;

  // 8-bit addressed accesses leave port 2 on its latch
  assign p2_addr_mode = ext_mem & ext_addr16;
  assign p2_drive = p2_addr_mode ? addr_high_byte : port_two_latch;
  // address ones are emitted with the strong pullup held on
  assign p2_force = p2_addr_mode ? addr_high_byte : 8'h00;

  qbp_qport u_qp1 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ph1(ph1),
    .state1_phase1_slot(state1_phase1_slot),
    .state1_phase2_slot(state1_phase2_slot),
    .drive_val(p1_drive),
    .force_strong(8'h00),
    .pin_sync(p1_sync),
    .drv_low_r(p1_pin_oe),
    .pu_strong_r(p1_pu_strong),
    .pu_weak_r(p1_pu_weak),
    .pu_vweak_r(p1_pu_vweak)
  );
  qbp_qport u_qp2 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ph1(ph1),
    .state1_phase1_slot(state1_phase1_slot),
    .state1_phase2_slot(state1_phase2_slot),
    .drive_val(p2_drive),
    .force_strong(p2_force),
    .pin_sync(p2_sync),
    .drv_low_r(p2_pin_oe),
    .pu_strong_r(p2_pu_strong),
    .pu_weak_r(p2_pu_weak),
    .pu_vweak_r(p2_pu_vweak)
  );
  qbp_qport u_qp3 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ph1(ph1),
    .state1_phase1_slot(state1_phase1_slot),
    .state1_phase2_slot(state1_phase2_slot),
    .drive_val(p3_drive),
    .force_strong(8'h00),
    .pin_sync(p3_sync),
    .drv_low_r(p3_pin_oe),
    .pu_strong_r(p3_pu_strong),
    .pu_weak_r(p3_pu_weak),
    .pu_vweak_r(p3_pu_vweak)
  );

  // quasi ports only ever pull low; highs come from the pullups
  assign p1_pin_o = 8'h00;
  assign p2_pin_o = 8'h00;
  assign p3_pin_o = 8'h00;

  // alternate inputs see the real pin, not the latch
  assign timer_two_clock_pin = p1_sync[`QBP_P1_T2_CLK];
  assign timer_two_reload_capture_pin =
    p1_sync[`QBP_P1_T2_RELOAD];
  assign serial_in_pin = p3_sync[`QBP_P3_SER_IN];
  assign ext_interrupt_zero_pin = p3_sync[`QBP_P3_EXT_INTERRUPT_ZERO_PIN];
  assign ext_interrupt_one_pin = p3_sync[`QBP_P3_EXT_INTERRUPT_ONE_PIN];
  assign timer_zero_clock_pin = p3_sync[`QBP_P3_T0_CLK];
  assign timer_one_clock_pin = p3_sync[`QBP_P3_T1_CLK];
endmodule // qbp_port_top

// File: core/qbp_qport.v
`timescale 1ns/1ps
module qbp_qport (
  input wire sys_clk, // core clock
  input wire rst_n, // synchronous reset, active low
  input wire ph1, // phase 1 slot of any state
  input wire state1_phase1_slot, // state 1 phase 1 slot
  input wire state1_phase2_slot, // state 1 phase 2 slot
  input wire [7:0] drive_val, // level the port wants on each pin
  input wire [7:0] force_strong, // hold strong pullup (address ones)
  input wire [7:0] pin_sync, // synchronised pin levels
  output reg [7:0] drv_low_r, // low-side driver on
  output reg [7:0] pu_strong_r, // strong pullup pulse
  output reg [7:0] pu_weak_r, // weak keeper pullup
  output reg [7:0] pu_vweak_r // very weak pullup
);
  reg [7:0] buf_r;

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_bit
      always @(posedge sys_clk) begin
        if (!rst_n) begin
          buf_r[i] <= 1'b1;
          drv_low_r[i] <= 1'b0;
          pu_vweak_r[i] <= 1'b1;
          pu_strong_r[i] <= 1'b0;
          pu_weak_r[i] <= 1'b1;
        end else begin
          // buffer looks at the latch only in phase 1, holds in phase 2
          if (ph1) begin
            buf_r[i] <= drive_val[i];
            drv_low_r[i] <= ~drive_val[i];
            pu_vweak_r[i] <= drive_val[i];
          end
          // boost for a rise seen at state1_phase1_slot, kept through state1_phase2_slot, or held on while force_strong is set
          if (force_strong[i])
            pu_strong_r[i] <= 1'b1;
          else if (state1_phase1_slot)
            pu_strong_r[i] <= drive_val[i] & ~buf_r[i];
          else if (!state1_phase2_slot)
            pu_strong_r[i] <= 1'b0;
          pu_weak_r[i] <= pin_sync[i];
        end
      end
    end
  endgenerate
endmodule // qbp_qport

// File: core/qbp_sync2.v
`timescale 1ns/1ps
module qbp_sync2 (
  input wire sys_clk, // core clock
  input wire rst_n, // synchronous reset, active low
  input wire [7:0] async_in, // raw pin levels
  output reg [7:0] sync_out // levels after two flops
);
  reg [7:0] meta_r;

  // reset to ones: an idle pin with pullups reads high
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_r <= 8'hFF;
      sync_out <= 8'hFF;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // qbp_sync2

// File: dv/qbp_pin_model.sv
`timescale 1ns/1ps
module qbp_pin_model (
  input logic sys_clk, // core clock
  input logic p0_ext_en, // outside drives port 0
  input logic [7:0] p0_pin_o, // port 0 driven level
  input logic [7:0] p0_pin_oe, // port 0 drive enable
  input logic [7:0] p0_ext, // level driven onto port 0 from outside
  input logic [7:0] p1_pin_oe, // port 1 low-side drivers
  input logic [7:0] p2_pin_oe, // port 2 low-side drivers
  input logic [7:0] p3_pin_oe, // port 3 low-side drivers
  input logic [23:0] ext_low, // outside pull-downs, ports 1 to 3
  output logic [7:0] p0_pin_i, // port 0 pin level
  output logic [7:0] p1_pin_i, // port 1 pin level
  output logic [7:0] p2_pin_i, // port 2 pin level
  output logic [7:0] p3_pin_i // port 3 pin level
);
  logic [7:0] flt = 8'h5A;
  // a floating port 0 line has no pullup, so it must not hold a level
  always @(posedge sys_clk) flt <= ~flt;
  assign p0_pin_i = p0_pin_oe & p0_pin_o |
    ~p0_pin_oe & (p0_ext_en ? p0_ext : flt);
  assign p1_pin_i = ~(p1_pin_oe | ext_low[7:0]);
  assign p2_pin_i = ~(p2_pin_oe | ext_low[15:8]);
  assign p3_pin_i = ~(p3_pin_oe | ext_low[23:16]);
endmodule // qbp_pin_model

// File: dv/qbp_port_assertions.sv
`timescale 1ns/1ps
module qbp_port_chk (
  input logic sys_clk, // core clock
  input logic rst_n, // synchronous reset, active low
  input logic s6p2, // state 6 phase 2 slot
  input logic ph1, // phase 1 slot
  input logic state1_phase1_slot, // state 1 phase 1 slot
  input logic state1_phase2_slot, // state 1 phase 2 slot
  input logic rd_rmw, // read is read-modify-write
  input logic bus_rvalid_r, // read answer strobe
  input logic ext_mem, // external access in progress
  input logic ext_drive, // port 0 emits address or data
  input logic serial_out_alt, // serial output alternate
  input logic ext_interrupt_zero_pin, // interrupt 0 input
  input logic [3:0] wr_port, // byte write strobes
  input logic [3:0] rd_port, // read strobes
  input logic [7:0] bus_wdata, // byte written
  input logic [7:0] bus_rdata_r, // byte read back
  input logic [7:0] mux_addr_data_low, // low address or data
  input logic [7:0] p0_pin_o, // port 0 driven level
  input logic [7:0] p0_pin_oe, // port 0 drive enable
  input logic [7:0] p0_pullup_r, // port 0 pullup
  input logic [7:0] p1_pin_i, // port 1 pin level
  input logic [7:0] p1_pin_oe, // port 1 low-side driver
  input logic [7:0] p1_pu_vweak, // port 1 very weak pullup
  input logic [7:0] p1_pu_weak, // port 1 keeper pullup
  input logic [7:0] p1_pu_strong, // port 1 strong pullup
  input logic [7:0] p3_pin_i, // port 3 pin level
  input logic [7:0] p3_pin_oe, // port 3 low-side driver
  input logic [7:0] p3_pu_strong // port 3 strong pullup
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_rvalid; |rd_port |=> bus_rvalid_r; endproperty
  a_rvalid: assert property (p_rvalid) else $error("no read answer");
  property p_wr_rd;
    s6p2 && wr_port == 4'h2 ##1 rd_port == 4'h2 && rd_rmw
      |=> bus_rdata_r == $past(bus_wdata, 2);
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("latch readback");
  property p_pin_rd;
    $stable(p3_pin_i) [*4] ##0 (rd_port == 4'h8 && !rd_rmw)
      |=> bus_rdata_r == $past(p3_pin_i);
  endproperty
  a_pin_rd: assert property (p_pin_rd) else $error("pin readback");
  property p_p0_fill;
    ext_mem ##1 (rd_port == 4'h1 && rd_rmw) |=> bus_rdata_r == 8'hFF;
  endproperty
  a_p0_fill: assert property (p_p0_fill) else $error("p0 fill");
  property p_bus_drv;
    ph1 && ext_mem && ext_drive |=> p0_pin_oe == 8'hFF &&
      p0_pin_o == $past(mux_addr_data_low) &&
      p0_pullup_r == $past(mux_addr_data_low);
  endproperty
  a_bus_drv: assert property (p_bus_drv) else $error("p0 bus drive");
  property p_pu_off; ph1 && !ext_mem |=> p0_pullup_r == 8'h00; endproperty
  a_pu_off: assert property (p_pu_off) else $error("p0 pullup on");
  property p_p0_float;
    s6p2 && wr_port == 4'h1 && !ext_mem ##1 ph1 && !ext_mem
      |=> p0_pin_oe == ~$past(bus_wdata, 2);
  endproperty
  a_p0_float: assert property (p_p0_float) else $error("p0 float");
  property p_alt_out;
    s6p2 && wr_port == 4'h8 ##1 ph1 |=> p3_pin_oe[1] ==
      !($past(bus_wdata[1], 2) && $past(serial_out_alt));
  endproperty
  a_alt_out: assert property (p_alt_out) else $error("alt output");
  property p_vweak; p1_pu_vweak == ~p1_pin_oe; endproperty
  a_vweak: assert property (p_vweak) else $error("very weak pullup");
  property p_alt_in;
    $stable(p3_pin_i) [*3] |=> ext_interrupt_zero_pin == $past(p3_pin_i[2]);
  endproperty
  a_alt_in: assert property (p_alt_in) else $error("alt input");
  property p_strong;
    p1_pu_strong != 8'h00 |-> $past(state1_phase1_slot) || $past(state1_phase2_slot);
  endproperty
  a_strong: assert property (p_strong) else $error("strong pullup");
  // keeper follows the pin three edges late through the sync pair
  property p_weak;
    $stable(p1_pin_i) [*3] |=> p1_pu_weak == $past(p1_pin_i);
  endproperty
  a_weak: assert property (p_weak) else $error("keeper pullup");
  property p_strong3;
    p3_pu_strong != 8'h00 |-> $past(state1_phase1_slot) || $past(state1_phase2_slot);
  endproperty
  a_strong3: assert property (p_strong3) else $error("p3 strong");
  c_bus: cover property (ph1 && ext_mem && ext_drive);
  c_strong: cover property (p1_pu_strong != 8'h00);
  c_pin: cover property (rd_port != 4'h0 && !rd_rmw);
endmodule // qbp_port_chk

bind qbp_port_top qbp_port_chk u_chk (.sys_clk, .rst_n, .s6p2, .ph1, .state1_phase1_slot,
  .state1_phase2_slot, .rd_rmw, .bus_rvalid_r, .ext_mem, .ext_drive, .serial_out_alt,
  .ext_interrupt_zero_pin, .wr_port, .rd_port, .bus_wdata, .bus_rdata_r,
  .mux_addr_data_low, .p0_pin_o, .p0_pin_oe, .p0_pullup_r, .p1_pin_i,
  .p1_pin_oe, .p1_pu_vweak, .p1_pu_weak, .p1_pu_strong, .p3_pin_i,
  .p3_pin_oe, .p3_pu_strong);

// File: dv/qbp_port_tb_top.sv
`timescale 1ns/1ps
module qbp_port_tb_top;
  logic sys_clk = 1'h0, rst_n = 1'h0, s6p2 = 1'h0, ph1 = 1'h0;
  logic state1_phase1_slot = 1'h0, state1_phase2_slot = 1'h0, bit_val = 1'h0, rd_rmw = 1'h0;
  logic ext_mem = 1'h0, ext_addr16 = 1'h0, ext_drive = 1'h0;
  logic timer_two_clock_out = 1'h1, serial_out_alt = 1'h1;
  logic wr_strobe_alt_n = 1'h1, rd_strobe_alt_n = 1'h1, p0_ext_en = 1'h1;
  logic [3:0] wr_port = 4'h0, bit_wr_port = 4'h0, rd_port = 4'h0;
  logic [2:0] bit_idx = 3'h0;
  logic [7:0] bus_wdata = 8'h00, mux_addr_data_low = 8'h00;
  logic [7:0] addr_high_byte = 8'h00, p0_ext = 8'h00;
  logic [23:0] ext_low = 24'h000000;
  logic [7:0] bus_rdata_r, ext_rdata_r, p0_pin_o, p0_pin_oe, p0_pullup_r;
  logic [7:0] p0_pin_i, p1_pin_i, p2_pin_i, p3_pin_i, p1_pu_strong;
  logic [7:0] p1_pin_oe, p2_pin_oe, p3_pin_oe;
  logic [7:0] p1_pu_weak, p2_pu_weak, p3_pu_weak, p2_pu_strong;
  logic [7:0] p1_pu_vweak, p2_pu_vweak, p3_pu_vweak;
  logic bus_rvalid_r, timer_two_clock_pin, timer_two_reload_capture_pin;
  logic serial_in_pin, ext_interrupt_zero_pin, ext_interrupt_one_pin;
  logic timer_zero_clock_pin, timer_one_clock_pin;
  int lat [4];
  int slot = 0, cyc = 0, n_fail = 0, checked = 0;

  qbp_port_top DUT (.sys_clk, .rst_n, .s6p2, .ph1, .state1_phase1_slot, .state1_phase2_slot, .wr_port,
    .bit_wr_port, .bit_idx, .bit_val, .bus_wdata, .rd_port, .rd_rmw,
    .bus_rdata_r, .bus_rvalid_r, .ext_mem, .ext_addr16, .ext_drive,
    .mux_addr_data_low, .addr_high_byte, .ext_rdata_r, .p0_pin_i,
    .p0_pin_o, .p0_pin_oe, .p0_pullup_r, .p1_pin_i, .p1_pin_o(),
    .p1_pin_oe, .p1_pu_strong, .p1_pu_weak, .p1_pu_vweak, .p2_pin_i,
    .p2_pin_o(), .p2_pin_oe, .p2_pu_strong, .p2_pu_weak,
    .p2_pu_vweak, .p3_pin_i, .p3_pin_o(), .p3_pin_oe, .p3_pu_strong(),
    .p3_pu_weak, .p3_pu_vweak, .timer_two_clock_out, .serial_out_alt,
    .wr_strobe_alt_n, .rd_strobe_alt_n, .timer_two_clock_pin,
    .timer_two_reload_capture_pin, .serial_in_pin, .ext_interrupt_zero_pin,
    .ext_interrupt_one_pin, .timer_zero_clock_pin, .timer_one_clock_pin);
  qbp_pin_model u_pins (.sys_clk, .p0_ext_en, .p0_pin_o, .p0_pin_oe,
    .p0_ext, .p1_pin_oe, .p2_pin_oe, .p3_pin_oe, .ext_low, .p0_pin_i,
    .p1_pin_i, .p2_pin_i, .p3_pin_i);

  always #2 sys_clk = ~sys_clk;
  // twelve one-cycle slots per machine cycle, slot 0 is state 1 phase 1
  always @(posedge sys_clk) begin
    slot <= (slot + 1) % 12;
    ph1 <= slot % 2 == 1;
    state1_phase1_slot <= slot == 11;
    state1_phase2_slot <= slot == 0;
    s6p2 <= slot == 10;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic close_out;
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] pin_exp(int p);
    logic [7:0] alt;
    alt = p == 1 ? {7'h7F, timer_two_clock_out} : p == 3 ?
      {rd_strobe_alt_n, wr_strobe_alt_n, 4'hF, serial_out_alt, 1'h1} : 8'hFF;
    return lat[p][7:0] & alt &
      (p == 0 ? p0_ext : ~ext_low[(p == 0 ? 0 : p - 1) * 8 +: 8]);
  endfunction

  // byte write when b < 0, else bit b takes d[0]; returns on the taking edge
  task automatic wr(int p, logic [7:0] d, int b = -1);
    @(posedge sys_clk iff slot == 10);
    if (b < 0) wr_port <= 4'h1 << p;
    else bit_wr_port <= 4'h1 << p;
    bus_wdata <= d;
    bit_idx <= b[2:0];
    bit_val <= d[0];
    @(posedge sys_clk);
    wr_port <= 4'h0;
    bit_wr_port <= 4'h0;
    if (b < 0) lat[p] = d;
    else lat[p][b] = d[0];
  endtask

  // pin reads wait for the phase 1 update and the two sync stages
  task automatic rd(int p, logic rmw);
    if (!rmw) repeat (5) @(posedge sys_clk);
    rd_port <= 4'h1 << p;
    rd_rmw <= rmw;
    @(posedge sys_clk);
    rd_port <= 4'h0;
    @(negedge sys_clk);
    chk(bus_rvalid_r, 1'h1);
    chk(bus_rdata_r, rmw ? lat[p][7:0] : pin_exp(p));
    @(posedge sys_clk);
  endtask

  task automatic reset_chk;
    rst_n <= 1'h0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'h1;
    lat = '{255, 255, 255, 255};
    for (int p = 0; p < 4; p++) begin
      rd(p, 1'h1);
      rd(p, 1'h0);
    end
  endtask

  task automatic settle;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  initial begin
    logic [7:0] e1, e3;
    int n;
    void'($urandom(8245));
    reset_chk();
    for (int k = 0; k < 12; k++) begin
      ext_low <= 24'($urandom);
      p0_ext <= 8'($urandom);
      {timer_two_clock_out, serial_out_alt} <= 2'($urandom);
      {wr_strobe_alt_n, rd_strobe_alt_n} <= 2'($urandom);
      wr(k % 4, 8'($urandom));
      rd(k % 4, 1'h1);
      rd(k % 4, 1'h0);
      // look between edges so no output is caught while it changes
      @(negedge sys_clk);
      e1 = pin_exp(1);
      e3 = pin_exp(3);
      chk({timer_one_clock_pin, timer_zero_clock_pin, ext_interrupt_one_pin,
        ext_interrupt_zero_pin, serial_in_pin, timer_two_reload_capture_pin,
        timer_two_clock_pin}, {e3[5:2], e3[0], e1[1:0]});
      chk({p3_pu_weak, p2_pu_weak, p1_pu_weak}, {e3, pin_exp(2), e1});
      chk({p3_pu_vweak, p2_pu_vweak}, 16'(~{p3_pin_oe, p2_pin_oe}));
      @(posedge sys_clk);
    end
    for (int b = 0; b < 8; b++) begin
      wr(2, 8'($urandom), b);
      rd(2, 1'h1);
    end
    ext_low <= 24'h000000;
    wr(1, 8'h00, 3);
    wr(1, 8'h01, 3);
    n = 0;
    repeat (12) begin
      @(negedge sys_clk);
      n += p1_pu_strong[3] === 1'h1;
    end
    chk(n, 2);
    rd(1, 1'h0);
    p0_ext_en <= 1'h0;
    mux_addr_data_low <= 8'($urandom);
    addr_high_byte <= 8'($urandom);
    {ext_mem, ext_drive, ext_addr16} <= 3'h7;
    lat[0] = 255;
    settle();
    chk(p0_pin_oe, 8'hFF);
    chk(p0_pin_o, mux_addr_data_low);
    chk(p0_pullup_r, mux_addr_data_low);
    chk(p2_pin_oe, 8'(~addr_high_byte));
    // address ones keep the strong pullup on for the whole access
    chk(p2_pu_strong, addr_high_byte);
    @(posedge sys_clk);
    ext_addr16 <= 1'h0;
    ext_drive <= 1'h0;
    p0_ext_en <= 1'h1;
    p0_ext <= 8'($urandom);
    settle();
    chk(p2_pin_oe, 8'(~lat[2][7:0]));
    chk(ext_rdata_r, p0_ext);
    chk(p0_pullup_r, 8'h00);
    @(posedge sys_clk);
    rd(0, 1'h1);
    rd(2, 1'h1);
    ext_mem <= 1'h0;
    rd(0, 1'h0);
    reset_chk();
    close_out();
  end
endmodule // qbp_port_tb_top
